// >>> shared/tec_pkg.sv
package tec_pkg;
  // clocks and line rates
  localparam int CLK_KHZ = 50000;
  localparam int T1_KHZ = 1544;
  localparam int E1_KHZ = 2048;
  // link timing in bit periods
  localparam int UNI_EDGES = 16;
  localparam int LOSS_BITS = 175;
  localparam int SETTLE_BITS = 22;
  localparam int REMOTE_LOOP_BIT_SETTLE_BITS = 44;
  // missing clock: longest time, so T1 bit length, rounded down
  localparam int LOSS_CYC_DEF = LOSS_BITS * CLK_KHZ / T1_KHZ;
  // reference clock period split between T1 and E1, in system cycles
  localparam int MCLK_SPLIT = 2 * CLK_KHZ / (T1_KHZ + E1_KHZ);
  localparam int MCLK_LOST = 4 * MCLK_SPLIT;
  // device register map
  localparam logic [7:0] ADDR_CR1 = 8'h10;
  localparam logic [7:0] ADDR_CR2 = 8'h11;
  localparam logic [7:0] ADDR_CR3 = 8'h13;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_COEF = 8'h20;
  localparam int COEF_IDX_W = 3;
  localparam logic [7:0] CR1_RST = 8'h00;
  localparam logic [7:0] CR2_RST = 8'h00;
  localparam logic [7:0] CR3_RST = 8'h00;
  localparam logic [7:0] COEF_RST = 8'h00;
  // field positions
  localparam int CR1_TX_ALL_ONES = 7;
  localparam int LBO_LSB = 3;
  localparam int LBO_MSB = 4;
  localparam int LEN_MSB = 2;
  localparam int CR2_HAUL = 0;
  localparam int CR2_TRI = 1;
  localparam int CR2_MATCHED_IMPEDANCE_BIT = 5;
  localparam int CR3_LOCAL_LOOP_BIT = 0;
  localparam int CR3_REMOTE_LOOP_BIT = 1;
  localparam int CR3_E1LH = 6;
  // pulse length codes
  localparam logic [2:0] LEN_E1_75 = 3'h0;
  localparam logic [2:0] LEN_E1_120 = 3'h1;
  localparam logic [2:0] LEN_FCC_A = 3'h2;
  // b8zs substitution 000VB0VB, oldest symbol in bit 7
  localparam logic [7:0] B8ZS_V = 8'h12;
  localparam logic [7:0] B8ZS_B = 8'h09;
  // framer registers
  localparam int FR_SEL_BIT = 7;
  localparam logic [7:0] FR_CTRL = 8'h80;
  localparam logic [7:0] FR_STAT = 8'h84;
  localparam int FR_RUN = 0;
  localparam int FR_UNI = 1;
  localparam logic [7:0] FR_CTRL_RST = 8'h00;
  localparam int FR_HALF_DIV = 16;

  typedef enum logic [1:0] {
    IMP_LOW = 2'b00,
    IMP_75 = 2'b01,
    IMP_100 = 2'b10,
    IMP_120 = 2'b11
  } tec_imp_t;
endpackage

// >>> shared/tec_link_if.sv
`timescale 1ns/1ns
interface tec_link_if;
  logic txClk;
  logic txPos;
  logic txNeg;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic regWr;
  logic regRd;
  logic [7:0] regRdata;
  modport device (
    input txClk, txPos, txNeg, regAddr, regWdata, regWr, regRd,
    output regRdata
  );
  modport framer (
    output txClk, txPos, txNeg, regAddr, regWdata, regWr, regRd,
    input regRdata
  );
endinterface

// >>> rtl/tec_sync.sv
`timescale 1ns/1ns
module tec_sync #(
  parameter int W = 1
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tec_sync_st_t;
  tec_sync_st_t st;
  tec_sync_st_t next_st;

  always_comb begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;
endmodule

// >>> rtl/tec_line_device.sv
`timescale 1ns/1ns
module tec_line_device
  import tec_pkg::*;
#(
  parameter int LOSS_CYC = LOSS_CYC_DEF
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // framer link
  tec_link_if.device link,
  // board pins
  input wire logic modePin,
  input wire logic mclk,
  input wire logic buildOutSelLo,
  input wire logic buildOutSelHi,
  // line driver
  output logic lineOutA,
  output logic lineOutB,
  output logic lineOe,
  // driver setup
  output tec_imp_t impedance,
  output logic [2:0] pulseShape,
  output logic [1:0] buildOutLevel,
  output logic sixVoltPeak,
  output logic noOvershoot,
  output logic e1Rate,
  output logic refFromMclk,
  // status
  output logic hostMode,
  output logic unipolar,
  output logic coderMode,
  output logic txClkLost,
  output logic settling
);
  typedef struct packed {
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] cr3;
    logic [7:0][7:0] coef;
    logic [7:0] rdata;
    logic clkPrev;
    logic [4:0] uniCnt;
    logic uni;
    logic [15:0] lossCnt;
    logic lost;
    logic mPrev;
    logic [7:0] mCnt;
    logic mclkOk;
    logic e1Clk;
    logic modePrev;
    logic [7:0] modeCnt;
    logic [5:0] settleCnt;
    logic [7:0] ctrlPrev;
    logic [7:0] sr;
    logic [7:0] subV;
    logic [7:0] subB;
    logic pol;
    logic outA;
    logic outB;
  } tec_dev_st_t;

  tec_dev_st_t st;
  tec_dev_st_t next_st;
  logic [6:0] syn;
  logic clkS, posS, negS, modeS, mclkS, lboLoS, lboHiS;
  logic shortHaul, triOn, tx_all_ones, local_loop_bit, remote_loop_bit, e1lh, txFall;
  logic [2:0] len;
  logic [1:0] lbo;
  logic [7:0] ctrlNow, srNew, vNew, bNew;
  logic mark;

  ////////////////////////////////////////////////////////////////////////
  // every pin from outside except the register port passes two flops first
  tec_sync #(.W(7)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({link.txClk, link.txPos, link.txNeg, modePin, mclk, buildOutSelLo, buildOutSelHi}),
    .dout(syn)
  );
  assign {clkS, posS, negS, modeS, mclkS, lboLoS, lboHiS} = syn;

  ////////////////////////////////////////////////////////////////////////
  // mode pin toggling means it is tied to the recovered clock
  assign hostMode = modeS && st.modeCnt == 8'h00;
  assign coderMode = st.uni && st.modeCnt != 8'h00;
  assign shortHaul = hostMode && st.cr2[CR2_HAUL];
  assign triOn = hostMode && st.cr2[CR2_TRI];
  assign remote_loop_bit = hostMode && st.cr3[CR3_REMOTE_LOOP_BIT];
  assign local_loop_bit = hostMode && st.cr3[CR3_LOCAL_LOOP_BIT];
  assign e1lh = hostMode && st.cr3[CR3_E1LH];
  // all-ones is ignored while remote loopback runs
  assign tx_all_ones = hostMode && st.cr1[CR1_TX_ALL_ONES] && !remote_loop_bit;
  assign len = st.cr1[LEN_MSB:0];
  // long haul takes build-out from control register 1 in host mode, from the select pins in hardware mode
  assign lbo = hostMode ? st.cr1[LBO_MSB:LBO_LSB] : {lboHiS, lboLoS};
  assign txFall = st.clkPrev && !clkS;
  assign ctrlNow = {tx_all_ones, len, lbo, local_loop_bit, remote_loop_bit};

  ////////////////////////////////////////////////////////////////////////
  // driver setup
  always_comb begin
    if (!hostMode) begin
      impedance = IMP_LOW;
    end else if (shortHaul) begin
      if (len == LEN_E1_75) begin
        impedance = IMP_75;
      end else if (len == LEN_E1_120) begin
        impedance = IMP_120;
      end else begin
        impedance = IMP_100;
      end
    end else if (!st.cr2[CR2_MATCHED_IMPEDANCE_BIT]) begin
      impedance = IMP_LOW;
    end else begin
      impedance = e1lh ? IMP_120 : IMP_100;
    end
  end

  assign pulseShape = shortHaul ? len : 3'h0;
  assign buildOutLevel = shortHaul ? 2'h0 : lbo;
  assign sixVoltPeak = shortHaul && len == LEN_FCC_A;
  assign noOvershoot = hostMode && e1lh && !st.cr2[CR2_HAUL];
  // host: short haul rate follows the written shape, long haul the E1 long-haul bit of control register 3; hardware: master clock rate
  assign e1Rate = !hostMode ? st.e1Clk :
    (shortHaul ? (len == LEN_E1_75 || len == LEN_E1_120) : e1lh);
  assign refFromMclk = st.mclkOk;
  assign unipolar = st.uni;
  assign txClkLost = st.lost;
  assign settling = st.settleCnt != 6'h00;
  assign lineOutA = st.outA;
  assign lineOutB = st.outB;
  assign lineOe = !(st.lost || triOn);
  assign link.regRdata = st.rdata;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    srNew = {st.sr[6:0], posS};
    vNew = {st.subV[6:0], 1'b0};
    bNew = {st.subB[6:0], 1'b0};
    mark = st.sr[7] || st.subB[7];
    next_st.clkPrev = clkS;
    next_st.modePrev = modeS;
    next_st.mPrev = mclkS;
    next_st.ctrlPrev = ctrlNow;
    // register port
    if (link.regWr) begin
      case (link.regAddr)
        ADDR_CR1: begin
          next_st.cr1 = link.regWdata;
        end
        ADDR_CR2: begin
          next_st.cr2 = link.regWdata;
        end
        ADDR_CR3: begin
          next_st.cr3 = link.regWdata;
        end
        default: begin
          if (link.regAddr[7:COEF_IDX_W] == ADDR_COEF[7:COEF_IDX_W]) begin
            next_st.coef[link.regAddr[COEF_IDX_W-1:0]] = link.regWdata;
          end
        end
      endcase
    end
    if (link.regRd) begin
      case (link.regAddr)
        ADDR_CR1: next_st.rdata = st.cr1;
        ADDR_CR2: next_st.rdata = st.cr2;
        ADDR_CR3: next_st.rdata = st.cr3;
        ADDR_STAT: next_st.rdata = {1'b0, e1Rate, st.mclkOk, settling, st.lost,
                                    coderMode, st.uni, hostMode};
        default: begin
          if (link.regAddr[7:COEF_IDX_W] == ADDR_COEF[7:COEF_IDX_W]) begin
            next_st.rdata = st.coef[link.regAddr[COEF_IDX_W-1:0]];
          end else begin
            next_st.rdata = 8'h00;
          end
        end
      endcase
    end
    // mode pin activity window
    if (modeS != st.modePrev) begin
      next_st.modeCnt = 8'(MCLK_LOST);
    end else if (st.modeCnt != 8'h00) begin
      next_st.modeCnt = st.modeCnt - 8'h01;
    end
    // master clock presence and rate
    if (mclkS && !st.mPrev) begin
      next_st.mclkOk = 1'b1;
      next_st.e1Clk = st.mCnt < 8'(MCLK_SPLIT);
      next_st.mCnt = 8'h00;
    end else if (st.mCnt == 8'(MCLK_LOST)) begin
      next_st.mclkOk = 1'b0;
    end else begin
      next_st.mCnt = st.mCnt + 8'h01;
    end
    // missing transmit clock, counted in system cycles
    if (txFall) begin
      next_st.lossCnt = 16'h0000;
      next_st.lost = 1'b0;
    end else if (st.lossCnt >= 16'(LOSS_CYC - 1)) begin
      next_st.lost = 1'b1;
    end else begin
      next_st.lossCnt = st.lossCnt + 16'h0001;
    end
    // settling counts transmit bits; remote loop takes longer
    if (ctrlNow != st.ctrlPrev) begin
      next_st.settleCnt = (ctrlNow[0] != st.ctrlPrev[0]) ? 6'(REMOTE_LOOP_BIT_SETTLE_BITS) :
        6'(SETTLE_BITS);
    end else if (txFall && st.settleCnt != 6'h00) begin
      next_st.settleCnt = st.settleCnt - 6'h01;
    end
    if (txFall) begin
      // unipolar detection
      if (!negS) begin
        next_st.uniCnt = 5'h00;
        next_st.uni = 1'b0;
      end else if (st.uniCnt > 5'(UNI_EDGES)) begin
        next_st.uni = 1'b1;
      end else begin
        next_st.uniCnt = st.uniCnt + 5'h01;
      end
      // single rail runs through an 8 bit window for b8zs lookahead
      if (coderMode && srNew == 8'h00 && vNew == 8'h00 && bNew == 8'h00) begin
        vNew = B8ZS_V;
        bNew = B8ZS_B;
      end
      next_st.sr = srNew;
      next_st.subV = vNew;
      next_st.subB = bNew;
      if (settling || st.lost || triOn) begin
        next_st.outA = 1'b0;
        next_st.outB = 1'b0;
      end else if (tx_all_ones || (st.uni && mark)) begin
        next_st.pol = !st.pol;
        next_st.outA = !st.pol;
        next_st.outB = st.pol;
      end else if (st.uni && st.subV[7]) begin
        next_st.outA = st.pol;
        next_st.outB = !st.pol;
      end else if (st.uni) begin
        next_st.outA = 1'b0;
        next_st.outB = 1'b0;
      end else begin
        // dual rail already carries alternate marks
        next_st.outA = posS;
        next_st.outB = negS;
      end
    end
    // blank at once: waiting for the next bit would leak stale marks
    if (settling || st.lost || triOn) begin
      next_st.outA = 1'b0;
      next_st.outB = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.cr1 <= CR1_RST;
      st.cr2 <= CR2_RST;
      st.cr3 <= CR3_RST;
      st.coef <= {8{COEF_RST}};
    end else begin
      st <= next_st;
    end
  end
endmodule

// >>> rtl/tec_framer.sv
`timescale 1ns/1ns
module tec_framer
  import tec_pkg::*;
#(
  parameter int HALF_DIV = FR_HALF_DIV
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // software port
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWdata,
  input wire logic cfgWr,
  input wire logic cfgRd,
  output logic [7:0] cfgRdata,
  // transmit bits
  input wire logic posBit,
  input wire logic negBit,
  output logic bitTake,
  // link to line device
  tec_link_if.framer link
);
  typedef struct packed {
    logic [7:0] div;
    logic clk;
    logic pos;
    logic neg;
    logic [7:0] ctrl;
    logic [7:0] bitCnt;
    logic [7:0] rdata;
    logic rdDev;
  } tec_fr_st_t;

  tec_fr_st_t st;
  tec_fr_st_t next_st;
  logic own, rise;

  ////////////////////////////////////////////////////////////////////////
  // high address bit selects the framer's own registers
  assign own = cfgAddr[FR_SEL_BIT];
  assign link.regAddr = cfgAddr;
  assign link.regWdata = cfgWdata;
  assign link.regWr = cfgWr && !own;
  assign link.regRd = cfgRd && !own;
  assign link.txClk = st.clk;
  assign link.txPos = st.pos;
  assign link.txNeg = st.neg;
  // device answers from its own flop one cycle after the strobe
  assign cfgRdata = st.rdDev ? link.regRdata : st.rdata;
  // new data on the rising edge: stable around the sampling fall
  assign rise = st.div == 8'(HALF_DIV - 1) && !st.clk && st.ctrl[FR_RUN];
  assign bitTake = rise;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.rdDev = cfgRd && !own;
    if (cfgWr && cfgAddr == FR_CTRL) begin
      next_st.ctrl = cfgWdata;
    end
    if (cfgRd && own) begin
      case (cfgAddr)
        FR_CTRL: next_st.rdata = st.ctrl;
        FR_STAT: next_st.rdata = st.bitCnt;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // stopping the clock lets the device see a missing clock
    if (st.div == 8'(HALF_DIV - 1)) begin
      next_st.div = 8'h00;
      next_st.clk = st.ctrl[FR_RUN] && !st.clk;
    end else begin
      next_st.div = st.div + 8'h01;
    end
    if (rise) begin
      next_st.pos = posBit;
      next_st.neg = st.ctrl[FR_UNI] || negBit;
      next_st.bitCnt = st.bitCnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl <= FR_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end
endmodule

// >>> tb/tec_link_checker.sv
`timescale 1ns/1ns
module tec_link_checker
  import tec_pkg::*;
#(
  parameter int LOSS_CYC = LOSS_CYC_DEF
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // link
  input wire logic txClk,
  input wire logic txPos,
  input wire logic txNeg,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // device side
  input wire logic lineOutA,
  input wire logic lineOutB,
  input wire logic lineOe,
  input wire logic unipolar,
  input wire logic txClkLost,
  input wire logic settling
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // pin-level fall seen here, the device lags by its synchroniser
  logic clkQ;
  logic fallNow;
  int gap;
  int negRun;
  assign fallNow = clkQ & ~txClk;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clkQ <= 1'b0;
      gap <= 0;
      negRun <= 0;
    end else begin
      clkQ <= txClk;
      gap <= fallNow ? 0 : (gap < 60000 ? gap + 1 : gap);
      if (fallNow) begin
        negRun <= txNeg ? (negRun < 40 ? negRun + 1 : negRun) : 0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_read_back: assert property (regWr && regAddr == ADDR_CR1 ##1 regRd && regAddr == ADDR_CR1
    |=> regRdata == $past(regWdata, 2)) else $error("length register read back wrong");
  a_lost_oe: assert property (txClkLost |-> !lineOe)
    else $error("driver on while clock lost");
  a_lost_late: assert property (gap > LOSS_CYC + 8 |-> txClkLost)
    else $error("missing clock not flagged");
  a_lost_early: assert property (gap > 6 && gap < LOSS_CYC - 8 |-> !txClkLost)
    else $error("clock flagged lost too early");
  a_data_stable: assert property (fallNow |-> $stable(txPos) && $stable(txNeg))
    else $error("data moved at sampling fall");
  a_uni_entry: assert property (fallNow && txNeg && negRun == 17 |-> ##[1:8] unipolar)
    else $error("unipolar not entered");
  a_uni_early: assert property (negRun >= 1 && negRun <= 16 |-> !unipolar)
    else $error("unipolar entered too early");
  a_uni_exit: assert property (fallNow && !txNeg |-> ##[1:8] !unipolar)
    else $error("unipolar not left");
  a_settle_quiet: assert property (settling [*2] |-> !lineOutA && !lineOutB)
    else $error("marks sent while settling");
  a_one_mark: assert property (!(lineOutA && lineOutB))
    else $error("both line outputs marked");
  c_uni: cover property ($rose(unipolar));
  c_lost: cover property ($rose(txClkLost));
  c_settle: cover property ($fell(settling));
endmodule

// >>> tb/t1e1_transmit_control_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
module t1e1_transmit_control_tb
  import tec_pkg::*;
;
  localparam int LOSS_N = 200;
  logic clk_sys, rst_n, cfgWr, cfgRd, posBit, negBit, modePin, mclk, boLo, boHi;
  logic [7:0] cfgAddr, cfgWdata, cfgRdata, rdv;
  logic lineOutA, lineOutB, lineOe, sixVoltPeak, noOvershoot, e1Rate, refFromMclk;
  logic hostMode, unipolar, coderMode, txClkLost, settling, prev;
  logic [2:0] pulseShape;
  logic [1:0] buildOutLevel;
  tec_imp_t impedance, expZ;
  int fails = 0;
  int checked = 0;
  int mclkHalf = 0;
  int cnt;
  tec_link_if link();
  tec_framer #(.HALF_DIV(4)) tec_framer_i (.clk_sys, .rst_n, .cfgAddr, .cfgWdata, .cfgWr,
    .cfgRd, .cfgRdata, .posBit, .negBit, .bitTake(), .link);
  tec_line_device #(.LOSS_CYC(LOSS_N)) tec_line_device_i (.clk_sys, .rst_n, .link, .modePin,
    .mclk, .buildOutSelLo(boLo), .buildOutSelHi(boHi), .lineOutA, .lineOutB, .lineOe,
    .impedance, .pulseShape, .buildOutLevel, .sixVoltPeak, .noOvershoot, .e1Rate,
    .refFromMclk, .hostMode, .unipolar, .coderMode, .txClkLost, .settling);
  tec_link_checker #(.LOSS_CYC(LOSS_N)) tec_link_checker_i (.clk_sys, .rst_n,
    .txClk(link.txClk), .txPos(link.txPos), .txNeg(link.txNeg), .regAddr(link.regAddr),
    .regWdata(link.regWdata), .regWr(link.regWr), .regRd(link.regRd),
    .regRdata(link.regRdata), .lineOutA, .lineOutB, .lineOe, .unipolar, .txClkLost,
    .settling);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // odd half periods keep nine in ten master clock edges off the system clock edges
  initial begin
    mclk = 1'b0;
    forever begin
      if (mclkHalf == 0) @(posedge clk_sys);
      else #(mclkHalf) mclk = ~mclk;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfgAddr <= a;
    cfgWdata <= d;
    cfgWr <= 1'b1;
    @(posedge clk_sys);
    cfgWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cfgAddr <= a;
    cfgRd <= 1'b1;
    @(posedge clk_sys);
    cfgRd <= 1'b0;
    #1;
    `CHK("rdata", e, cfgRdata)
    @(posedge clk_sys);
  endtask
  // bounded wait for the driver to come out of settling
  task automatic waitSettle;
    cnt = 0;
    while (settling !== 1'b0 && cnt < 600) begin
      pause(1);
      cnt++;
    end
    if (cnt >= 600) begin
      fails++;
      end_sim();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, cfgWr, cfgRd, posBit, negBit, modePin, boLo, boHi} = '0;
    cfgAddr = 8'h00;
    cfgWdata = 8'h00;
    pause(2);
    rst_n <= 1'b1;
    pause(4);
    `CHK("imp", IMP_LOW, impedance)
    `CHK("host", 1'b0, hostMode)
    rd(ADDR_CR2, CR2_RST);
    wr(FR_CTRL, 8'h01);
    posBit <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      {boHi, boLo} <= i[1:0];
      pause(4);
      `CHK("lbo", i[1:0], buildOutLevel)
    end
    mclkHalf = 243;
    pause(150);
    `CHK("ref", 1'b1, refFromMclk)
    `CHK("e1", 1'b1, e1Rate)
    mclkHalf = 323;
    pause(150);
    `CHK("e1", 1'b0, e1Rate)
    mclkHalf = 0;
    pause(150);
    `CHK("ref", 1'b0, refFromMclk)
    waitSettle();
    pause(64);
    `CHK("a", 2'b10, {lineOutA, lineOutB})
    {posBit, negBit} <= 2'b01;
    pause(64);
    `CHK("b", 2'b01, {lineOutA, lineOutB})
    modePin <= 1'b1;
    pause(200);
    `CHK("host", 1'b1, hostMode)
    wr(ADDR_CR2, 8'h20);
    wr(ADDR_CR3, 8'h00);
    pause(2);
    `CHK("imp", IMP_100, impedance)
    wr(ADDR_CR3, 8'h40);
    pause(2);
    `CHK("imp", IMP_120, impedance)
    `CHK("novs", 1'b1, noOvershoot)
    `CHK("e1", 1'b1, e1Rate)
    wr(ADDR_CR2, 8'h00);
    pause(2);
    `CHK("imp", IMP_LOW, impedance)
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CR1, {3'h0, i[1:0], 3'h0});
      pause(2);
      `CHK("lbo", i[1:0], buildOutLevel)
    end
    waitSettle();
    wr(ADDR_CR1, 8'h08);
    pause(2);
    `CHK("settle", 1'b1, settling)
    waitSettle();
    `CHK("settlelen", 1'b1, cnt >= 20 * 8 && cnt <= 26 * 8)
    wr(ADDR_CR2, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CR1, {5'h00, i[2:0]});
      rd(ADDR_CR1, {5'h00, i[2:0]});
      expZ = i == 0 ? IMP_75 : (i == 1 ? IMP_120 : IMP_100);
      `CHK("shape", i[2:0], pulseShape)
      `CHK("imp", expZ, impedance)
      `CHK("6v", i == 2, sixVoltPeak)
      `CHK("e1", i < 2, e1Rate)
      `CHK("novs", 1'b0, noOvershoot)
    end
    wr(ADDR_CR2, 8'h03);
    pause(2);
    `CHK("oe", 1'b0, lineOe)
    wr(ADDR_CR2, 8'h00);
    pause(2);
    `CHK("oe", 1'b1, lineOe)
    for (int i = 0; i < 8; i++) wr(ADDR_COEF + 8'(i), 8'h5a ^ 8'(i));
    for (int i = 0; i < 8; i++) rd(ADDR_COEF + 8'(i), 8'h5a ^ 8'(i));
    rd(8'h15, 8'h00);
    {posBit, negBit} <= 2'b10;
    wr(FR_CTRL, 8'h03);
    pause(180);
    `CHK("uni", 1'b1, unipolar)
    waitSettle();
    pause(80);
    prev = lineOutA;
    // all ones single rail: marks must swap rails every bit
    for (int i = 0; i < 8; i++) begin
      pause(8);
      `CHK("ami", {~prev, prev}, {lineOutA, lineOutB})
      prev = lineOutA;
    end
    for (int i = 0; i < 10; i++) begin
      modePin <= ~modePin;
      pause(20);
    end
    `CHK("coder", 1'b1, coderMode)
    modePin <= 1'b1;
    wr(FR_CTRL, 8'h01);
    {posBit, negBit} <= 2'b00;
    pause(200);
    `CHK("uni", 1'b0, unipolar)
    wr(FR_CTRL, 8'h00);
    pause(LOSS_N + 30);
    `CHK("lost", 2'b10, {txClkLost, lineOe})
    wr(FR_CTRL, 8'h01);
    pause(40);
    `CHK("lost", 1'b0, txClkLost)
    end_sim();
  end
endmodule
